// >>> inc/wdt_pkg.sv
/*
  constants for the watchdog timeout unit: config word fields, prescale and
  postscale ratios, nominal timing.
  assumes a 10 MHz system clock and a low-power rc clock tick arriving as a
  one-cycle enable pulse synchronous to clk.
*/
// Behaviour
// RULE_01: watchdog counts low-power rc ticks; enabling it requests that oscillator on.
// RULE_02: prescaler divides by 32 or 128, chosen by prescale select bit.
// RULE_03: at 32 kHz prescaler alone gives about 1 ms or 4 ms.
// RULE_04: postscaler divides further, sixteen ratios from 1:1 to 1:32768.
// RULE_05: any device reset clears watchdog, prescaler and postscaler counts.
// RULE_06: completed clock switch, software or fail-safe, clears all counts.
// RULE_07: switch completes when go bit clears and status copies next selection.
// RULE_08: power-save instruction entering sleep or idle clears all counts.
// RULE_09: leaving sleep or idle back to normal clears all counts.
// RULE_10: watchdog clear instruction in normal execution clears all counts.
// RULE_11: enabled watchdog counts in sleep and idle; timeout there wakes core.
// RULE_12: software clears the sleep or idle status flag after watchdog wake.
// RULE_13: hard enable bit set means watchdog always runs.
// RULE_14: hard enable clear means watchdog runs only while soft enable is set.
// RULE_15: every device reset clears the soft enable bit.
// RULE_16: timeout sets sticky flag; only software clears it. rstn also clears it here.
// RULE_17: timeout in normal running causes a device reset request.
package watchdog_pkg;
    localparam int          CFG_W          = 8;
    localparam int          CFG_POST_LSB   = 0;
    localparam int          CFG_POST_W     = 4;
    localparam int          CFG_PRE_BIT    = 4;
    localparam int          CFG_HARD_BIT   = 7;
    localparam int          PRE_W          = 7;
    localparam logic [6:0]  PRE_LAST_5BIT  = 7'h1F;
    localparam logic [6:0]  PRE_LAST_7BIT  = 7'h7F;
    localparam int          POST_W         = 15;
    localparam int          RC_OSC_HZ      = 32000;
    localparam int          BASE_5BIT_US   = 1000;
    localparam int          BASE_7BIT_US   = 4000;
    localparam int          CLK_HZ         = 10000000;
    localparam int          OSC_SEL_W      = 3;
    localparam logic        SOFT_EN_RESET  = 1'b0;

    typedef enum logic [1:0] {
        PM_RUN   = 2'b00,
        PM_SLEEP = 2'b01,
        PM_IDLE  = 2'b10
    } power_mode_t;
endpackage

// >>> rtl/wdt_postscaler.sv
/*
  postscaler counter: counts prescaler wraps and flags when the chosen
  power-of-two ratio is reached.
  assumes clear and step are synchronous single-cycle strobes.
*/
`timescale 1ns/1ps
module watchdog_postscaler
    import watchdog_pkg::*;
#(
    parameter int WIDTH = POST_W
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               ce,
    // control
    input  wire logic               clear,
    input  wire logic               step,
    input  wire logic [3:0]         ratio_sel,
    // result
    output logic                    expire
);
    initial begin
        if (WIDTH != POST_W) $error("postscaler width must be 15");
    end

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic [WIDTH-1:0] last_value;

    // last count for 2^sel ratio
    assign last_value = WIDTH'((32'h1 << ratio_sel) - 32'h1);
    assign expire     = step && (count_reg == last_value);
    assign count_next = (clear || expire) ? '0 : count_reg + WIDTH'(1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else if (ce && (clear || step)) begin
            count_reg <= count_next;
        end
    end
endmodule

// >>> rtl/watchdog_timeout_unit.sv
/*
  watchdog timeout unit: prescaler, postscaler, enable logic, clear sources,
  sticky timeout flag, wake and reset requests.
  assumes low_power_rc_tick is a one-cycle pulse per low-power rc period, and that the
  oscillator and power-save controllers drive their strobes synchronously.
*/
`timescale 1ns/1ps
module watchdog_timeout_unit
    import watchdog_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    // low-power rc oscillator
    input  wire logic                 low_power_rc_tick,
    output logic                      low_power_rc_osc_en,
    // configuration
    input  wire logic [CFG_W-1:0]     watchdog_config_word,
    // reset control register bits
    input  wire logic                 soft_enable_set,
    input  wire logic                 soft_enable_clr,
    input  wire logic                 timeout_flag_clr,
    output logic                      watchdog_soft_enable,
    output logic                      watchdog_timeout_flag,
    // clock switch status
    input  wire logic                 clock_switch_go,
    input  wire logic [OSC_SEL_W-1:0] next_clock_select,
    input  wire logic [OSC_SEL_W-1:0] current_clock_status,
    // core events
    input  wire logic                 power_save_instr,
    input  wire logic                 power_save_idle,
    input  wire logic                 watchdog_clear_instr,
    input  wire logic                 wake_other,
    // results
    output logic                      core_wake,
    output logic                      device_reset_req,
    output logic                      in_power_save
);
    logic [PRE_W-1:0]      pre_reg;
    logic                  go_reg;
    logic [OSC_SEL_W-1:0]  cur_reg;
    power_mode_t           mode_reg;
    power_mode_t           mode_next;
    logic                  soft_en_next;
    logic                  flag_next;
    logic                  en_next;

    wire logic             hard_en      = watchdog_config_word[CFG_HARD_BIT];
    wire logic             pre_7bit     = watchdog_config_word[CFG_PRE_BIT];
    wire logic [3:0]       post_sel     =
        watchdog_config_word[CFG_POST_LSB +: CFG_POST_W];

    // RULE_13 RULE_14 enable select
    wire logic             watchdog_enabled = hard_en || watchdog_soft_enable;
    // RULE_02 prescale ratio
    wire logic [PRE_W-1:0] pre_last     = pre_7bit ? PRE_LAST_7BIT : PRE_LAST_5BIT;
    // RULE_03 base period from 32 or 128 ticks
    wire logic             pre_wrap     = watchdog_enabled && low_power_rc_tick &&
                                          (pre_reg == pre_last);
    // RULE_07 switch complete detect
    wire logic             switch_done  = go_reg && !clock_switch_go &&
                                          (current_clock_status == next_clock_select) &&
                                          (cur_reg != current_clock_status);
    wire logic             running      = (mode_reg == PM_RUN);
    wire logic             post_expire;
    wire logic             timeout      = post_expire;
    // RULE_09 exit on wake
    wire logic             wake_exit    = !running && wake_other;
    wire logic             leave_save   = wake_exit || (!running && timeout);
    // RULE_06 RULE_08 RULE_10 clear sources
    // timeout exit kept out of the step gate, else step loops through expire
    wire logic             clear_cmd    = switch_done || power_save_instr || wake_exit ||
                                          (watchdog_clear_instr && running) ||
                                          !watchdog_enabled;
    wire logic             clear_all    = clear_cmd || leave_save;

    // RULE_04 postscaler ratios
    watchdog_postscaler #(
        .WIDTH     (POST_W)
    ) u_post (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .clear     (clear_all),
        .step      (pre_wrap && !clear_cmd),
        .ratio_sel (post_sel),
        .expire    (post_expire)
    );

    assign mode_next = (running && power_save_instr) ?
                           (power_save_idle ? PM_IDLE : PM_SLEEP) :
                       leave_save ? PM_RUN : mode_reg;
    // RULE_16 set wins over clear
    assign flag_next    = timeout || (watchdog_timeout_flag && !timeout_flag_clr);
    assign soft_en_next = soft_enable_set || (watchdog_soft_enable && !soft_enable_clr);
    assign en_next      = hard_en || soft_en_next;

    // RULE_05 RULE_15 reset clears counts and soft enable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_reg               <= '0;
            go_reg                <= 1'b0;
            cur_reg               <= '0;
            mode_reg              <= PM_RUN;
            watchdog_soft_enable  <= SOFT_EN_RESET;
            watchdog_timeout_flag <= 1'b0;
            low_power_rc_osc_en   <= 1'b0;
            core_wake             <= 1'b0;
            device_reset_req      <= 1'b0;
            in_power_save         <= 1'b0;
        end else if (ce) begin
            // RULE_02 prescaler count
            if (clear_all || pre_wrap) begin
                pre_reg <= '0;
            end else if (low_power_rc_tick) begin
                pre_reg <= pre_reg + PRE_W'(1);
            end
            go_reg                <= clock_switch_go;
            cur_reg               <= current_clock_status;
            mode_reg              <= mode_next;
            watchdog_soft_enable  <= soft_en_next;
            watchdog_timeout_flag <= flag_next;
            // RULE_01 oscillator follows enable
            low_power_rc_osc_en   <= en_next;
            // RULE_11 wake from sleep or idle
            core_wake             <= timeout && !running;
            // RULE_17 reset in normal run
            device_reset_req      <= timeout && running;
            in_power_save         <= (mode_next != PM_RUN);
        end
    end

    // RULE_12 software clears sleep and idle flags elsewhere

    // assertions
    a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn) // RULE_16
        ce && watchdog_timeout_flag && !timeout_flag_clr |=> watchdog_timeout_flag)
        else $error("timeout flag dropped without clear");
    a_flag_set: assert property (@(posedge clk) disable iff (!rstn) // RULE_16
        ce && timeout |=> watchdog_timeout_flag)
        else $error("timeout did not set flag");
    a_reset_run: assert property (@(posedge clk) disable iff (!rstn) // RULE_17
        ce && timeout && running |=> device_reset_req && !core_wake)
        else $error("run timeout gave no reset");
    a_wake_save: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
        ce && timeout && !running |=> core_wake && !device_reset_req)
        else $error("sleep timeout gave no wake");
    a_pre_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
        ce && watchdog_clear_instr && running |=> pre_reg == '0)
        else $error("clear instruction left prescaler");
    a_save_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
        ce && power_save_instr |=> pre_reg == '0)
        else $error("power save left prescaler");
    a_switch_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
        ce && switch_done |=> pre_reg == '0)
        else $error("clock switch left prescaler");
    a_exit_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
        ce && leave_save |=> pre_reg == '0 && mode_reg == PM_RUN)
        else $error("exit left prescaler");
    a_hard_on: assert property (@(posedge clk) disable iff (!rstn) // RULE_13
        ce && hard_en |=> low_power_rc_osc_en)
        else $error("hard enable did not run oscillator");
    a_soft_off: assert property (@(posedge clk) disable iff (!rstn) // RULE_14
        ce && !hard_en && !watchdog_soft_enable |=> pre_reg == '0)
        else $error("disabled watchdog advanced");
    a_pre_bound: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
        pre_reg <= pre_last || $past(pre_7bit) != pre_7bit)
        else $error("prescaler past its ratio");

    c_run_timeout:  cover property (@(posedge clk) disable iff (!rstn) device_reset_req);
    c_sleep_wake:   cover property (@(posedge clk) disable iff (!rstn) core_wake);
    c_switch:       cover property (@(posedge clk) disable iff (!rstn) switch_done);
    c_idle_entry:   cover property (@(posedge clk) disable iff (!rstn) mode_reg == PM_IDLE);
    c_flag_cleared: cover property (@(posedge clk) disable iff (!rstn)
        watchdog_timeout_flag ##1 !watchdog_timeout_flag);
endmodule

// >>> test/tb_watchdog_timeout_unit.sv
/*
  self-checking bench for the watchdog timeout unit: run, sleep, idle,
  clears and enables, driven by hand-written scenario tasks.
  assumes a 10 MHz clk and rc_tick given as one-cycle pulses by the bench.
*/
`timescale 1ns/1ps
module tb_watchdog_timeout_unit;
    import watchdog_pkg::*;
    logic                 clk = 1'b0, rstn = 1'b0, rc_tick = 1'b0, ce_in = 1'b1;
    logic [CFG_W-1:0]     cfg = 8'h80;
    logic                 sset = 1'b0, sclr = 1'b0, fclr = 1'b0, go = 1'b0;
    logic [OSC_SEL_W-1:0] nsel = 3'h0, csel = 3'h0;
    logic                 psi = 1'b0, psidle = 1'b0, clri = 1'b0, wake_o = 1'b0;
    logic                 osc_en, soft_en, flag, wake, rst_req, in_ps;
    int                   err_total = 0, checks = 0, rst_cnt = 0, wake_cnt = 0;

    always #50 clk = ~clk;

    watchdog_timeout_unit i_dut (.clk(clk), .rstn(rstn), .ce(ce_in), .low_power_rc_tick(rc_tick),
        .low_power_rc_osc_en(osc_en), .watchdog_config_word(cfg), .soft_enable_set(sset),
        .soft_enable_clr(sclr), .timeout_flag_clr(fclr), .watchdog_soft_enable(soft_en),
        .watchdog_timeout_flag(flag), .clock_switch_go(go), .next_clock_select(nsel),
        .current_clock_status(csel), .power_save_instr(psi), .power_save_idle(psidle),
        .watchdog_clear_instr(clri), .wake_other(wake_o), .core_wake(wake),
        .device_reset_req(rst_req), .in_power_save(in_ps));

    // pulses are one cycle wide, so count them rather than sample them late
    always @(negedge clk) begin
        if (rst_req === 1'b1) rst_cnt++;
        if (wake === 1'b1) wake_cnt++;
    end

    task automatic report_and_stop;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            rc_tick = 1'b1;
            cyc(1);
            rc_tick = 1'b0;
            cyc(1);
        end
    endtask

    task automatic chk_events(input int r, input int w);
        cyc(3);
        chk("reset pulses", rst_cnt[7:0], r[7:0]);
        chk("wake pulses", wake_cnt[7:0], w[7:0]);
        rst_cnt = 0;
        wake_cnt = 0;
    endtask

    task automatic do_reset(input logic [7:0] c);
        cfg = c;
        rstn = 1'b0;
        cyc(2);
        chk("soft enable in reset", {7'h00, soft_en}, 8'h00);
        chk("flag in reset", {7'h00, flag}, 8'h00);
        rstn = 1'b1;
        cyc(1);
        rst_cnt = 0;
        wake_cnt = 0;
    endtask

    task automatic s_ratio(input logic [7:0] c, input int n);
        do_reset(c);
        ticks(n - 1);
        chk_events(0, 0);
        ticks(1);
        chk_events(1, 0);
        cyc(5);
        chk("sticky flag", {7'h00, flag}, 8'h01);
        fclr = 1'b1;
        cyc(1);
        fclr = 1'b0;
        chk("flag cleared", {7'h00, flag}, 8'h00);
    endtask

    task automatic s_soft;
        do_reset(8'h00);
        chk("osc off", {7'h00, osc_en}, 8'h00);
        ticks(40);
        chk_events(0, 0);
        sset = 1'b1;
        cyc(1);
        sset = 1'b0;
        chk("osc on", {7'h00, osc_en}, 8'h01);
        ticks(32);
        chk_events(1, 0);
        sclr = 1'b1;
        cyc(1);
        sclr = 1'b0;
        chk("soft off", {6'h00, soft_en, osc_en}, 8'h00);
    endtask

    task automatic s_clears;
        do_reset(8'h80);
        ticks(20);
        do_reset(8'h80);
        ticks(31);
        chk_events(0, 0);
        clri = 1'b1;
        cyc(1);
        clri = 1'b0;
        ce_in = 1'b0;
        ticks(40);
        ce_in = 1'b1;
        ticks(31);
        chk_events(0, 0);
        nsel = 3'h3;
        go = 1'b1;
        cyc(2);
        go = 1'b0;
        csel = 3'h3;
        cyc(1);
        ticks(31);
        chk_events(0, 0);
        ticks(1);
        chk_events(1, 0);
    endtask

    task automatic s_sleep(input logic idle);
        do_reset(8'h80);
        psidle = idle;
        ticks(31);
        psi = 1'b1;
        cyc(1);
        psi = 1'b0;
        chk("in power save", {7'h00, in_ps}, 8'h01);
        ticks(31);
        chk_events(0, 0);
        ticks(1);
        chk_events(0, 1);
        chk("resumed", {6'h00, in_ps, flag}, 8'h01);
        psi = 1'b1;
        cyc(1);
        psi = 1'b0;
        ticks(31);
        wake_o = 1'b1;
        cyc(1);
        wake_o = 1'b0;
        ticks(31);
        chk_events(0, 0);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        #10;
        rstn = 1'b1;
        cyc(1);
        s_ratio(8'h80, 32);
        s_ratio(8'h90, 128);
        s_ratio(8'h81, 64);
        s_ratio(8'h92, 512);
        s_soft();
        s_clears();
        s_sleep(1'b0);
        s_sleep(1'b1);
        report_and_stop();
    end

    // bounded run: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
endmodule
